/* File: design/pwm_out_pkg.sv */
// Shared constants and carrier types for the PWM output-stage controller
package pwm_out_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int         ADDR_W          = 5;
  localparam logic [4:0] REG_DEL_OFS     = 5'h00;
  localparam logic [4:0] REG_STEER_OFS   = 5'h04;
  localparam logic [4:0] REG_MODE_OFS    = 5'h08;
  localparam logic [4:0] REG_SHUT_OFS    = 5'h0C;
  localparam logic [4:0] REG_PORT_OFS    = 5'h10;
  localparam logic [4:0] REG_IRQ_STS_OFS = 5'h14;
  localparam logic [4:0] REG_IRQ_CLR_OFS = 5'h18;
  localparam logic [4:0] REG_IRQ_EN_OFS  = 5'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RESTART_BIT    = 7;
  localparam int DCOUNT_W       = 7;
  localparam int STEER_SYNC_BIT = 4;
  localparam int CMPL_LSB       = 6;
  localparam int BRIDGE_LSB     = 6;
  localparam int SHUT_FLAG_BIT  = 7;
  localparam int SHUT_EN_BIT    = 4;
  localparam int SHUT_AC_LSB    = 2;
  localparam int SHUT_BD_LSB    = 0;
  localparam int DRV_EN_LSB     = 4;
  localparam int NUM_PINS       = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DEL_RST    = 8'h00;
  localparam logic [7:0] STEER_RST  = 8'h01;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] SHUT_RST   = 8'h00;
  localparam logic [7:0] PORT_RST   = 8'h00;
  localparam logic [1:0] IRQ_RST    = 2'h0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PWM_HI   = 2'h3;
  localparam logic [1:0] BRIDGE_SINGLE = 2'h0;
  localparam logic [1:0] BRIDGE_HALF   = 2'h2;
  localparam logic [1:0] CMPL_STEER    = 2'h0;
  localparam logic [1:0] SHUT_DRV_LOW  = 2'h0;
  localparam logic [1:0] SHUT_DRV_HIGH = 2'h1;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Interrupt status bits
  localparam int IRQ_W       = 2;
  localparam int IRQ_SHUT    = 0;
  localparam int IRQ_RESTART = 1;

  // ----------------------------------------------------------------
  // Timing: one instruction cycle is four oscillator periods
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int INSTR_CYCLE_NS    = 4 * CLK_PERIOD_NS;
  localparam int INSTR_CYCLE_CLKS  = INSTR_CYCLE_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // AXI4-Lite carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

endpackage : pwm_out_pkg

/* File: design/deadband_delay.sv */
// Delays the rising edge of an active-high level by a programmed count
`timescale 1ns/100ps
module deadband_delay import pwm_out_pkg::*; #(
  parameter int CNT_W = DCOUNT_W,
  parameter int CLKS  = INSTR_CYCLE_CLKS
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             hold,
  input  wire logic             levelIn,
  input  wire logic [CNT_W-1:0] delayCount,
  output logic                  levelOut
);

  localparam int TICK_W = CNT_W + $clog2(CLKS) + 1;

  typedef struct packed {
    logic [TICK_W-1:0] ticks;
    logic              done;
  } db_st_t;

  db_st_t            st_ff;
  db_st_t            nxt_st;
  logic [TICK_W-1:0] target;

  assign target = TICK_W'(delayCount) * TICK_W'(CLKS);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (!hold) begin
      if (!levelIn) begin
        nxt_st.ticks = '0;                      // Falling edge never delayed
        nxt_st.done  = 1'b0;
      end else if (!st_ff.done) begin
        if (st_ff.ticks + TICK_W'(1) >= target) begin
          nxt_st.done = 1'b1;                   // Exact count of instruction cycles
        end else begin
          nxt_st.ticks = st_ff.ticks + TICK_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Zero count passes the edge straight through
  assign levelOut = levelIn & ((delayCount == '0) | st_ff.done);

endmodule : deadband_delay

/* File: design/pwm_output_control.sv */
// PWM output stage: auto-restart, dead band, pulse steering, register slave
// Functional notes
// - Bit 7 of the delay register enables automatic restart after shutdown.
// - With restart on, flag stays set during condition, hardware clears it after.
// - Outputs stay disabled after condition clears until next PWM period starts.
// - With restart off, only software clears the shutdown flag.
// - Half-bridge dead band delays only inactive-to-active transitions.
// - Bits 6:0 give dead band in instruction cycles of four clocks.
// - Steering exists only with mode bits 3:2 = 11 and bridge bits 00.
// - Steering bits 3:0 route PWM to D..A; clear bit gives port control.
// - Mode bits 1:0 set polarity of every steered output.
// - Shutdown forces only outputs carrying PWM; port pins unaffected.
// - Sync bit 0: new steering applies right after the register write.
// - Sync bit 1: new steering applies at next PWM period start.
// - Pair field 00 uses steering; 01 A/B, 10 A/C, 11 A/D.
// - In sleep all state and driven outputs freeze, except that a shutdown condition still forces pins, then resume.
// - In primary idle the module keeps running unchanged.
// - Any reset restores register defaults and makes pins inputs.
// - Shutdown sets flag and at once drives pairs low, high or off.
// - Software writes to the flag are ignored while condition is present.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module pwm_output_control import pwm_out_pkg::*; (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire axil_req_t           axiReq,
  output axil_rsp_t                axiRsp,
  input  wire logic                pwmWave,
  input  wire logic                periodStart,
  input  wire logic                shutdownCond,
  input  wire logic                sleepMode,
  output logic [NUM_PINS-1:0]      pinOut,
  output logic [NUM_PINS-1:0]      pinOe,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0]   awAddr;
    logic                awHave;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    logic                wHave;
    logic                bValid;
    logic [1:0]          bResp;
    logic                rValid;
    logic [31:0]         rData;
    logic [1:0]          rResp;
    logic [7:0]          restartDeadband;
    logic [7:0]          steerCtl;
    logic [3:0]          steerEff;
    logic [7:0]          modeCtl;
    logic [7:0]          shutCtl;
    logic                shutFlag;
    logic                outsOff;
    logic [7:0]          portCtl;
    logic [IRQ_W-1:0]    irqSts;
    logic [IRQ_W-1:0]    irqEn;
    logic [NUM_PINS-1:0] pinNorm;
    logic [NUM_PINS-1:0] pwmSel;
  } st_t;

  st_t                 st_ff;
  st_t                 nxt_st;
  logic [1:0]          dbIn;
  logic [1:0]          dbOut;
  logic                condActive;
  logic                shutNow;
  logic                wrFire;
  logic                wrLow;
  logic [7:0]          wrByte;
  logic                singleMode;
  logic                halfMode;
  logic [1:0]          cmplSel;
  logic [NUM_PINS-1:0] actLevel;
  logic [NUM_PINS-1:0] pwmSelNow;
  logic [NUM_PINS-1:0] polLow;
  logic [IRQ_W-1:0]    irqSet;
  logic [IRQ_W-1:0]    irqClr;
  logic                flagSwSet;

  // ----------------------------------------------------------------
  // Dead band, one path per half of the complementary pair
  // ----------------------------------------------------------------
  assign dbIn = {~pwmWave, pwmWave};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gDead
      deadband_delay #(
        .CNT_W (DCOUNT_W),
        .CLKS  (INSTR_CYCLE_CLKS)
      ) uDead (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .hold       (sleepMode),
        .levelIn    (dbIn[gi]),
        .delayCount (st_ff.restartDeadband[DCOUNT_W-1:0]),
        .levelOut   (dbOut[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign singleMode = (st_ff.modeCtl[3:2] == MODE_PWM_HI) &&
                      (st_ff.modeCtl[BRIDGE_LSB +: 2] == BRIDGE_SINGLE);
  assign halfMode   = (st_ff.modeCtl[3:2] == MODE_PWM_HI) &&
                      (st_ff.modeCtl[BRIDGE_LSB +: 2] == BRIDGE_HALF);
  assign cmplSel    = st_ff.steerCtl[CMPL_LSB +: 2];
  assign condActive = shutdownCond & st_ff.shutCtl[SHUT_EN_BIT];
  assign wrFire     = st_ff.awHave & st_ff.wHave & ~st_ff.bValid;
  assign wrLow      = wrFire & st_ff.wStrb[0];
  assign wrByte     = st_ff.wData[7:0];

  // Pins A and C share one polarity, B and D the other
  assign polLow = {st_ff.modeCtl[0], st_ff.modeCtl[1], st_ff.modeCtl[0], st_ff.modeCtl[1]};

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  always_comb begin
    actLevel  = '0;
    pwmSelNow = '0;
    if (halfMode) begin
      actLevel[0]  = dbOut[0];                  // Dead band on active-going edges
      actLevel[1]  = dbOut[1];
      pwmSelNow[0] = 1'b1;
      pwmSelNow[1] = 1'b1;
    end else if (singleMode && cmplSel != CMPL_STEER) begin
      actLevel[0]       = dbOut[0];             // Pair A with B, C or D
      pwmSelNow[0]      = 1'b1;
      actLevel[cmplSel] = dbOut[1];
      pwmSelNow[cmplSel] = 1'b1;
    end else if (singleMode) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        actLevel[i]  = pwmWave;                 // Same waveform on each steered pin
        pwmSelNow[i] = st_ff.steerEff[i];
      end
    end else if (st_ff.modeCtl[3:2] == MODE_PWM_HI) begin
      actLevel[0]  = pwmWave;
      pwmSelNow[0] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st    = st_ff;
    irqSet    = '0;
    irqClr    = '0;
    flagSwSet = 1'b0;
    // Clock stopped in sleep: nothing moves, pins keep their value unless a shutdown condition forces them
    if (!sleepMode) begin
      // Write address and data taken in either order
      if (axiReq.awvalid && !st_ff.awHave && !st_ff.bValid) begin
        nxt_st.awAddr = axiReq.awaddr;
        nxt_st.awHave = 1'b1;
      end
      if (axiReq.wvalid && !st_ff.wHave && !st_ff.bValid) begin
        nxt_st.wData = axiReq.wdata;
        nxt_st.wStrb = axiReq.wstrb;
        nxt_st.wHave = 1'b1;
      end
      if (st_ff.bValid && axiReq.bready) begin
        nxt_st.bValid = 1'b0;
      end
      if (wrFire) begin
        nxt_st.awHave = 1'b0;
        nxt_st.wHave  = 1'b0;
        nxt_st.bValid = 1'b1;
        nxt_st.bResp  = RESP_OKAY;
        unique case ({st_ff.awAddr[ADDR_W-1:2], 2'b00})
          REG_DEL_OFS: begin
            if (wrLow) nxt_st.restartDeadband = wrByte;
          end
          REG_STEER_OFS: begin
            if (wrLow) begin
              nxt_st.steerCtl = {wrByte[7:6], 1'b0, wrByte[4:0]};
              if (!wrByte[STEER_SYNC_BIT]) begin
                nxt_st.steerEff = wrByte[3:0];  // Takes hold straight after the write
              end
            end
          end
          REG_MODE_OFS: begin
            if (wrLow) nxt_st.modeCtl = {wrByte[7:6], 2'b00, wrByte[3:0]};
          end
          REG_SHUT_OFS: begin
            if (wrLow) begin
              nxt_st.shutCtl = {3'b000, wrByte[4:0]};
              if (wrByte[SHUT_FLAG_BIT]) begin
                nxt_st.shutFlag = 1'b1;         // Firmware-forced shutdown
                flagSwSet       = 1'b1;
              end else if (!condActive) begin
                nxt_st.shutFlag = 1'b0;         // Clear ignored while condition holds
              end
            end
          end
          REG_PORT_OFS: begin
            if (wrLow) nxt_st.portCtl = wrByte;
          end
          REG_IRQ_CLR_OFS: begin
            if (wrLow) irqClr = wrByte[IRQ_W-1:0];
          end
          REG_IRQ_EN_OFS: begin
            if (wrLow) nxt_st.irqEn = wrByte[IRQ_W-1:0];
          end
          REG_IRQ_STS_OFS: begin
            nxt_st.bResp = RESP_OKAY;           // Read-only, write dropped
          end
          default: begin
            nxt_st.bResp = RESP_SLVERR;
          end
        endcase
      end

      // Read channel, one cycle to answer
      if (st_ff.rValid && axiReq.rready) begin
        nxt_st.rValid = 1'b0;
      end
      if (axiReq.arvalid && !st_ff.rValid) begin
        nxt_st.rValid = 1'b1;
        nxt_st.rResp  = RESP_OKAY;
        nxt_st.rData  = '0;
        unique case ({axiReq.araddr[ADDR_W-1:2], 2'b00})
          REG_DEL_OFS:     nxt_st.rData[7:0] = st_ff.restartDeadband;
          REG_STEER_OFS:   nxt_st.rData[7:0] = st_ff.steerCtl;
          REG_MODE_OFS:    nxt_st.rData[7:0] = st_ff.modeCtl;
          REG_SHUT_OFS:    nxt_st.rData[7:0] = {st_ff.shutFlag, st_ff.shutCtl[6:0]};
          REG_PORT_OFS:    nxt_st.rData[7:0] = st_ff.portCtl;
          REG_IRQ_STS_OFS: nxt_st.rData[IRQ_W-1:0] = st_ff.irqSts;
          REG_IRQ_CLR_OFS: nxt_st.rData = '0;
          REG_IRQ_EN_OFS:  nxt_st.rData[IRQ_W-1:0] = st_ff.irqEn;
          default:         nxt_st.rResp = RESP_SLVERR;
        endcase
      end

      // Shutdown flag: condition always wins over a clear
      if (condActive) begin
        nxt_st.shutFlag = 1'b1;                 // Held set while condition lasts
        if (!st_ff.shutFlag) irqSet[IRQ_SHUT] = 1'b1;
      end else if (st_ff.restartDeadband[RESTART_BIT] && st_ff.shutFlag && !flagSwSet) begin
        nxt_st.shutFlag = 1'b0;                 // Hardware restart
      end
      // Without restart enable the flag is left for software
      if (flagSwSet && !st_ff.shutFlag) irqSet[IRQ_SHUT] = 1'b1;

      // Outputs wait for a fresh period before coming back
      if (nxt_st.shutFlag) begin
        nxt_st.outsOff = 1'b1;
      end else if (periodStart && st_ff.outsOff) begin
        nxt_st.outsOff          = 1'b0;
        irqSet[IRQ_RESTART]     = 1'b1;
      end

      // Deferred steering update at period start
      if (periodStart && st_ff.steerCtl[STEER_SYNC_BIT]) begin
        nxt_st.steerEff = st_ff.steerCtl[3:0];
      end

      // Registered pin levels; polarity applied to every PWM pin
      for (int i = 0; i < NUM_PINS; i++) begin
        nxt_st.pinNorm[i] = pwmSelNow[i] ? (actLevel[i] ^ polLow[i]) : st_ff.portCtl[i];
      end
      nxt_st.pwmSel = pwmSelNow;

      // Sticky status, a new event beats a clear in the same cycle
      nxt_st.irqSts = (st_ff.irqSts & ~irqClr) | irqSet;
    end
  end

  // ----------------------------------------------------------------
  // Registers; no dependence on idle state, the clock keeps running
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_ff                 <= '0;                // Pins fall back to inputs
      st_ff.restartDeadband <= DEL_RST;
      st_ff.steerCtl        <= STEER_RST;
      st_ff.steerEff        <= STEER_RST[3:0];
      st_ff.modeCtl         <= MODE_RST;
      st_ff.shutCtl         <= SHUT_RST;
      st_ff.portCtl         <= PORT_RST;
      st_ff.irqSts          <= IRQ_RST;
      st_ff.irqEn           <= IRQ_RST;
      st_ff.bResp           <= RESP_OKAY;
      st_ff.rResp           <= RESP_OKAY;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Combinational path from the condition so shutdown needs no clock edge
  assign shutNow = condActive | st_ff.outsOff;

  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : gPin
      logic [1:0] pairState;
      logic       forced;
      assign pairState = (gi % 2 == 0) ? st_ff.shutCtl[SHUT_AC_LSB +: 2]
                                        : st_ff.shutCtl[SHUT_BD_LSB +: 2];
      assign forced    = shutNow & st_ff.pwmSel[gi];                 // Port pins untouched
      assign pinOut[gi] = forced ? (pairState == SHUT_DRV_HIGH) : st_ff.pinNorm[gi];
      assign pinOe[gi]  = st_ff.portCtl[DRV_EN_LSB + gi] & ~(forced & pairState[1]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus answers and interrupt
  // ----------------------------------------------------------------
  assign axiRsp.awready = ~st_ff.awHave & ~st_ff.bValid & ~sleepMode;
  assign axiRsp.wready  = ~st_ff.wHave & ~st_ff.bValid & ~sleepMode;
  assign axiRsp.bvalid  = st_ff.bValid;
  assign axiRsp.bresp   = st_ff.bResp;
  assign axiRsp.arready = ~st_ff.rValid & ~sleepMode;
  assign axiRsp.rvalid  = st_ff.rValid;
  assign axiRsp.rdata   = st_ff.rData;
  assign axiRsp.rresp   = st_ff.rResp;
  assign irq            = |(st_ff.irqSts & st_ff.irqEn);

endmodule : pwm_output_control

/* File: testbench/pwm_out_sva.sv */
// Concurrent checks on the PWM output-stage ports
`timescale 1ns/100ps
module pwm_out_sva import pwm_out_pkg::*; (
  input wire logic                clk_sys,
  input wire logic                rstn,
  input wire axil_req_t           axiReq,
  input wire axil_rsp_t           axiRsp,
  input wire logic                pwmWave,
  input wire logic                periodStart,
  input wire logic                shutdownCond,
  input wire logic                sleepMode,
  input wire logic [NUM_PINS-1:0] pinOut,
  input wire logic [NUM_PINS-1:0] pinOe,
  input wire logic                irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ----------------
  // Sequences
  // ----------------
  sequence s_wr_taken;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence
  sequence s_asleep;
    (sleepMode && !shutdownCond) ##1 (sleepMode && !shutdownCond);
  endsequence

  // ----------------
  // Properties
  // ----------------
  property p_wr_resp; s_wr_taken |-> ##2 axiRsp.bvalid; endproperty
  property p_rd_resp; axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid; endproperty
  property p_b_hold; axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid; endproperty
  property p_r_hold; axiRsp.rvalid && !axiReq.rready |=> $stable(axiRsp.rdata); endproperty
  property p_b_done; axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid; endproperty
  property p_b_busy; axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready; endproperty
  property p_rd_hi; axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h000000; endproperty
  property p_sleep_bus; sleepMode |-> !axiRsp.awready && !axiRsp.arready; endproperty
  property p_sleep_pins; s_asleep |-> $stable(pinOut) && $stable(pinOe); endproperty
  property p_rst_pins; $rose(rstn) |-> pinOe == 4'h0 && !irq; endproperty

  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  a_b_done: assert property (p_b_done) else $error("write answer stuck");
  a_b_busy: assert property (p_b_busy) else $error("write taken during answer");
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  a_sleep_bus: assert property (p_sleep_bus) else $error("bus taken in sleep");
  a_sleep_pins: assert property (p_sleep_pins) else $error("pins moved in sleep");
  a_rst_pins: assert property (p_rst_pins) else $error("pins driven after reset");
endmodule : pwm_out_sva

bind pwm_output_control pwm_out_sva u_sva (.clk_sys(clk_sys), .rstn(rstn), .axiReq(axiReq),
  .axiRsp(axiRsp), .pwmWave(pwmWave), .periodStart(periodStart), .shutdownCond(shutdownCond),
  .sleepMode(sleepMode), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));

/* File: testbench/bridge_driver_model.sv */
// Gate inputs of the external bridge switch drivers
`timescale 1ns/100ps
module bridge_driver_model import pwm_out_pkg::*; (
  input wire logic [NUM_PINS-1:0] pinOut,
  input wire logic [NUM_PINS-1:0] pinOe,
  output logic     [NUM_PINS-1:0] padLevel
);
  // Pulled low: a released pin keeps its switch off
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      padLevel[i] = pinOe[i] ? pinOut[i] : 1'b0;
    end
  end
endmodule : bridge_driver_model

/* File: testbench/enhanced_pwm_output_control_tb.sv */
// Self-checking bench for the PWM output-stage controller
`timescale 1ns/100ps
module enhanced_pwm_output_control_tb import pwm_out_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  axil_req_t   req = '0;
  axil_rsp_t   rsp;
  logic        pwmWave = 1'b0;
  logic        periodStart = 1'b0;
  logic        shutdownCond = 1'b0;
  logic        sleepMode = 1'b0;
  logic [3:0]  pinOut, pinOe, padLevel;
  logic        irq;
  logic [31:0] rd;
  int          n_fail = 0;
  int          n_checks = 0;
  int          n;

  always #5 clk_sys = ~clk_sys;

  pwm_output_control DUT (.clk_sys(clk_sys), .rstn(rstn), .axiReq(req), .axiRsp(rsp),
    .pwmWave(pwmWave), .periodStart(periodStart), .shutdownCond(shutdownCond),
    .sleepMode(sleepMode), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
  bridge_driver_model drivers (.pinOut(pinOut), .pinOe(pinOe), .padLevel(padLevel));

  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req.awaddr <= a;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    #1;
  endtask : wr

  task automatic rdr(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    req.rready <= 1'b0;
    #1;
  endtask : rdr

  task automatic pulse_period;
    @(posedge clk_sys);
    periodStart <= 1'b1;
    @(posedge clk_sys);
    periodStart <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : pulse_period

  task automatic set_pwm(input logic v, input int cyc);
    @(posedge clk_sys);
    pwmWave <= v;
    repeat (cyc) @(posedge clk_sys);
    #1;
  endtask : set_pwm

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs;
    logic [4:0] adr [7] = '{REG_DEL_OFS, REG_STEER_OFS, REG_MODE_OFS, REG_SHUT_OFS,
                            REG_PORT_OFS, REG_IRQ_STS_OFS, REG_IRQ_EN_OFS};
    logic [7:0] rv [7] = '{DEL_RST, STEER_RST, MODE_RST, SHUT_RST, PORT_RST,
                           {6'h00, IRQ_RST}, {6'h00, IRQ_RST}};
    chk("pin enables", 32'h0, {28'h0, pinOe});
    for (int i = 0; i < 7; i++) begin
      rdr(adr[i], rd);
      chk("reset value", {24'h0, rv[i]}, rd);
    end
    wr(REG_STEER_OFS, 8'hFF);
    rdr(REG_STEER_OFS, rd);
    chk("steer bit5", 32'hDF, rd);
  endtask : t_regs

  task automatic t_steer;
    wr(REG_MODE_OFS, 8'h0C);
    wr(REG_PORT_OFS, 8'hF2);
    wr(REG_STEER_OFS, 8'h05);
    set_pwm(1'b1, 3);
    chk("steer high", 32'h7, {28'h0, pinOut});
    wr(REG_MODE_OFS, 8'h0F);
    set_pwm(1'b0, 3);
    chk("steer low pol", 32'h7, {28'h0, pinOut});
    wr(REG_STEER_OFS, 8'h01);
    chk("steer now", 32'h3, {28'h0, pinOut});
    wr(REG_STEER_OFS, 8'h15);
    chk("steer wait", 32'h3, {28'h0, pinOut});
    pulse_period();
    chk("steer period", 32'h7, {28'h0, pinOut});
  endtask : t_steer

  task automatic t_shut;
    wr(REG_STEER_OFS, 8'h01);
    wr(REG_SHUT_OFS, 8'h10);
    @(posedge clk_sys);
    shutdownCond <= 1'b1;
    #1;
    chk("forced low", 32'h2, {28'h0, pinOut});
    repeat (2) @(posedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(REG_IRQ_EN_OFS, 8'h01);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(REG_SHUT_OFS, 8'h10);
    rdr(REG_SHUT_OFS, rd);
    chk("flag kept", 32'h90, rd);
    @(posedge clk_sys);
    shutdownCond <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdr(REG_SHUT_OFS, rd);
    chk("flag no restart", 32'h90, rd);
    wr(REG_IRQ_CLR_OFS, 8'h01);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(REG_SHUT_OFS, 8'h10);
    pulse_period();
    chk("soft restart", 32'h3, {28'h0, pinOut});
    wr(REG_SHUT_OFS, 8'h18);
    @(posedge clk_sys);
    shutdownCond <= 1'b1;
    #1;
    chk("released pad", 32'hA, {28'h0, pinOe[1:0], padLevel[1:0]});
    wr(REG_DEL_OFS, 8'h80);
    rdr(REG_SHUT_OFS, rd);
    chk("flag held", 32'h98, rd);
    @(posedge clk_sys);
    shutdownCond <= 1'b0;
    rdr(REG_SHUT_OFS, rd);
    chk("flag auto clear", 32'h18, rd);
    chk("still off", 32'hE, {28'h0, pinOe});
    pulse_period();
    chk("auto restart", 32'hF3, {24'h0, pinOe, pinOut});
    rdr(REG_IRQ_STS_OFS, rd);
    chk("status", 32'h3, rd);
    wr(REG_SHUT_OFS, 8'h00);
  endtask : t_shut

  task automatic t_dead;
    logic [6:0] cnt [2] = '{7'd3, 7'd0};
    wr(REG_MODE_OFS, 8'h8C);
    for (int k = 0; k < 2; k++) begin
      wr(REG_DEL_OFS, {1'b0, cnt[k]});
      set_pwm(1'b1, 0);
      n = 0;
      do begin
        @(posedge clk_sys);
        #1;
        n++;
      end while (pinOut[0] !== 1'b1 && n < 200);
      chk("rise delay", 1 + INSTR_CYCLE_CLKS * cnt[k], n);
      set_pwm(1'b0, 1);
      chk("fall at once", 32'h0, {31'h0, pinOut[0]});
    end
  endtask : t_dead

  task automatic t_pair;
    wr(REG_MODE_OFS, 8'h0C);
    for (int k = 1; k < 4; k++) begin
      wr(REG_STEER_OFS, {k[1:0], 6'h00});
      set_pwm(1'b1, 3);
      chk("pair on", 32'h1, {30'h0, pinOut[k], pinOut[0]});
      set_pwm(1'b0, 3);
      chk("pair off", 32'h2, {30'h0, pinOut[k], pinOut[0]});
    end
  endtask : t_pair

  task automatic t_sleep;
    @(posedge clk_sys);
    sleepMode <= 1'b1;
    set_pwm(1'b1, 4);
    chk("sleep frozen", 32'h0, {31'h0, pinOut[0]});
    sleepMode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("wake resumes", 32'h1, {31'h0, pinOut[0]});
  endtask : t_sleep

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_steer();
    t_shut();
    t_dead();
    t_pair();
    t_sleep();
    end_of_test();
  end
endmodule : enhanced_pwm_output_control_tb
